// File: hw/flsr_pkg.sv
// shared constants of the fuse, lock and signature readback block
package flsr_pkg;
    // wishbone byte offsets
    localparam logic [7:0] ADR_CTRL      = 8'h00;
    localparam logic [7:0] ADR_IRQ_STAT  = 8'h04;
    localparam logic [7:0] ADR_IRQ_MASK  = 8'h08;
    localparam logic [7:0] ADR_OP_ADDR   = 8'h0C;
    // control/status bit positions
    localparam int CB_EN        = 0;
    localparam int CB_ERASE     = 1;
    localparam int CB_WRITE     = 2;
    localparam int CB_LOCKFUSE  = 3;
    localparam int CB_REEN      = 4;
    localparam int CB_SIG       = 5;
    localparam int CB_BUSY      = 6;
    // interrupt status bit positions
    localparam int IRQ_W        = 3;
    localparam int IRQ_DONE     = 0;
    localparam int IRQ_EXPIRE   = 1;
    localparam int IRQ_REFUSE   = 2;
    // pointer addresses of lock/fuse readout
    localparam logic [15:0] Z_FUSE_LOW  = 16'h0000;
    localparam logic [15:0] Z_LOCK      = 16'h0001;
    localparam logic [15:0] Z_FUSE_EXT  = 16'h0002;
    localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
    // pointer addresses of signature row
    localparam logic [15:0] Z_SIG1      = 16'h0000;
    localparam logic [15:0] Z_CAL       = 16'h0001;
    localparam logic [15:0] Z_SIG2      = 16'h0002;
    localparam logic [15:0] Z_SIG3      = 16'h0004;
    localparam logic [7:0]  RSVD_BYTE   = 8'hFF;
    localparam logic [7:0]  BLOCK_BYTE  = 8'hFF;
    // instruction windows in cpu cycles
    localparam logic [2:0]  LOAD_WINDOW  = 3'h3;
    localparam logic [2:0]  STORE_WINDOW = 3'h4;
    // flash operation timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int PROG_MIN_NS   = 3_700_000;
    localparam int PROG_MAX_NS   = 4_500_000;
    localparam int PROG_MIN_CYC  = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_MAX_CYC  = PROG_MAX_NS / CLK_PERIOD_NS;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : flsr_pkg

// File: hw/flsr_top.sv
// fuse, lock and signature readback with timed self-programming control
// How it works
// R1 - armed lock read returns lock bits
// R2 - software points at lock address first
// R3 - armed bits clear on completion or timeout
// R4 - unarmed load is ordinary flash read
// R5 - pointer zero returns low fuse byte
// R6 - pointer three returns high fuse byte
// R7 - pointer two returns extended fuse byte
// R8 - programmed reads zero, unprogrammed reads one
// R9 - armed signature read returns addressed byte
// R10 - signature bits clear on completion or timeout
// R11 - signature bytes at zero, two, four; calibration one
// R12 - flash write survives a reset
// R13 - flash operations timed 3.7 to 4.5 ms
// R14 - software polls enable clear before commands
// R15 - software waits eeprom idle, masks interrupts
// R16 - busy flag holds until read re-enable
// R17 - boot-only fetch, concurrent section blocked
// R18 - store within four cycles or abandoned
// R19 - expired request leaves no side effect
`timescale 1ns/100ps
module flsr_top
    import flsr_pkg::*;
#(
    parameter int          PROG_CYCLES = PROG_MIN_CYC,
    parameter logic [15:0] RWW_LIMIT   = 16'h1800,
    // identity bytes: values are arbitrary
    parameter logic [7:0]  SIG_BYTE1   = 8'h5A,
    parameter logic [7:0]  SIG_BYTE2   = 8'h3C,
    parameter logic [7:0]  SIG_BYTE3   = 8'h11
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [31:0] WB_DAT_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic        WB_WE_I,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic [15:0] Z_PTR,
    input  wire logic        LOAD_REQ,
    input  wire logic        STORE_REQ,
    input  wire logic [15:0] STORE_DATA,
    input  wire logic [7:0]  FLASH_RD_DATA,
    input  wire logic        EEPROM_WRITE_ACTIVE,
    input  wire logic [7:0]  LOCK_BITS,
    input  wire logic [7:0]  FUSE_LOW,
    input  wire logic [7:0]  FUSE_HIGH,
    input  wire logic [7:0]  FUSE_EXT,
    input  wire logic [7:0]  CAL_BYTE,
    output logic             LOAD_VALID,
    output logic      [7:0]  LOAD_DATA,
    output logic             LOAD_BLOCKED,
    output logic             ERASE_START,
    output logic             WRITE_START,
    output logic             LOCK_WRITE_START,
    output logic             BUFFER_LOAD,
    output logic             BUFFER_CLEAR,
    output logic      [15:0] OP_ADDR,
    output logic      [15:0] OP_DATA,
    output logic             FLASH_OP_BUSY,
    output logic             FETCH_BOOT_ONLY,
    output logic             IRQ
);

    localparam int TW = (PROG_CYCLES > 1) ? $clog2(PROG_CYCLES) : 1;

    if (PROG_CYCLES < 1 || PROG_CYCLES > PROG_MAX_CYC) begin : g_chk
        $error("PROG_CYCLES out of range");
    end

    typedef struct packed {
        logic                 en;
        logic                 erase;
        logic                 wr;
        logic                 lockfuse;
        logic                 reen;
        logic                 sig;
        logic                 busy_flag;
        logic [2:0]           lwin;
        logic [2:0]           swin;
        logic                 op_busy;
        logic [TW-1:0]        timer;
        logic [IRQ_W-1:0]     irq_st;
        logic [IRQ_W-1:0]     irq_mask;
        logic                 ack;
        logic [31:0]          rdata;
        logic                 ld_valid;
        logic                 ld_blocked;
        logic [7:0]           ld_data;
        logic                 erase_go;
        logic                 write_go;
        logic                 lock_go;
        logic                 buf_load;
        logic                 buf_clear;
        logic [15:0]          op_addr;
        logic [15:0]          op_data;
    } flsr_state_t;

    flsr_state_t s;
    flsr_state_t next_s;

    // lock and fuse byte selected by pointer
    function automatic logic [7:0] flsr_fuse_sel(
        input logic [15:0] z,
        input logic [7:0]  lock,
        input logic [7:0]  fl,
        input logic [7:0]  fh,
        input logic [7:0]  fe
    );
        logic [7:0] v;
        v = RSVD_BYTE;
        case (z)
            Z_FUSE_LOW:  v = fl;
            Z_LOCK:      v = lock;
            Z_FUSE_EXT:  v = fe;
            Z_FUSE_HIGH: v = fh;
            default:     v = RSVD_BYTE;
        endcase
        return v;
    endfunction : flsr_fuse_sel

    // signature row byte selected by pointer
    function automatic logic [7:0] flsr_sig_sel(
        input logic [15:0] z,
        input logic [7:0]  cal
    );
        logic [7:0] v;
        v = RSVD_BYTE;
        case (z)
            Z_SIG1:  v = SIG_BYTE1;
            Z_CAL:   v = cal;
            Z_SIG2:  v = SIG_BYTE2;
            Z_SIG3:  v = SIG_BYTE3;
            default: v = RSVD_BYTE;
        endcase
        return v;
    endfunction : flsr_sig_sel

    logic             bus_req;
    logic             wr_hit;
    logic             rd_hit;
    logic [IRQ_W-1:0] irq_ev;
    logic [IRQ_W-1:0] irq_clr;
    logic             read_armed;
    logic             load_take;
    logic             store_take;
    logic             arm_ok;
    logic             win_open;

    always_comb begin
        next_s = s;
        irq_ev = '0;
        irq_clr = '0;
        arm_ok = 1'b0;
        next_s.ack = 1'b0;
        next_s.ld_valid = 1'b0;
        next_s.ld_blocked = 1'b0;
        next_s.erase_go = 1'b0;
        next_s.write_go = 1'b0;
        next_s.lock_go = 1'b0;
        next_s.buf_load = 1'b0;
        next_s.buf_clear = 1'b0;

        bus_req = WB_CYC_I & WB_STB_I & ~s.ack;
        wr_hit = bus_req & WB_WE_I & WB_SEL_I[0];
        rd_hit = bus_req & ~WB_WE_I;
        read_armed = s.en & (s.lockfuse | s.sig) & ~s.op_busy;
        win_open = (s.lwin != 3'h0) | (s.swin != 3'h0);
        load_take = LOAD_REQ & read_armed & (s.lwin != 3'h0);
        store_take = STORE_REQ & s.en & ~s.op_busy & (s.swin != 3'h0);

        // window countdown
        if (s.lwin != 3'h0) begin
            next_s.lwin = s.lwin - 3'h1;
        end
        if (s.swin != 3'h0) begin
            next_s.swin = s.swin - 3'h1;
        end

        // R3 expiry clears armed bits
        // R10 signature timeout clears bits
        // R19 expiry has no side effect
        if (win_open && !load_take && !store_take && !s.op_busy
            && next_s.lwin == 3'h0 && next_s.swin == 3'h0) begin
            next_s.en = 1'b0;
            next_s.erase = 1'b0;
            next_s.wr = 1'b0;
            next_s.lockfuse = 1'b0;
            next_s.reen = 1'b0;
            next_s.sig = 1'b0;
            irq_ev[IRQ_EXPIRE] = 1'b1;
        end

        if (load_take) begin
            next_s.ld_valid = 1'b1;
            // R8 raw bits, programmed is zero
            if (s.sig) begin
                // R9 signature byte readout
                // R11 signature row addressing
                next_s.ld_data = flsr_sig_sel(Z_PTR, CAL_BYTE);
            end else begin
                // R1 R5 R6 R7 lock and fuse readout
                // R2 pointer preloaded by software
                next_s.ld_data = flsr_fuse_sel(Z_PTR, LOCK_BITS,
                                               FUSE_LOW, FUSE_HIGH, FUSE_EXT);
            end
            // R3 R10 clear after readout
            next_s.en = 1'b0;
            next_s.lockfuse = 1'b0;
            next_s.sig = 1'b0;
            next_s.lwin = 3'h0;
            next_s.swin = 3'h0;
        end else if (LOAD_REQ) begin
            next_s.ld_valid = 1'b1;
            // R17 concurrent section read blocked
            if (s.busy_flag && Z_PTR < RWW_LIMIT) begin
                next_s.ld_blocked = 1'b1;
                next_s.ld_data = BLOCK_BYTE;
            end else begin
                // R4 ordinary flash byte read
                next_s.ld_data = FLASH_RD_DATA;
            end
        end

        // R18 store only inside its window
        if (store_take) begin
            next_s.lwin = 3'h0;
            next_s.swin = 3'h0;
            next_s.op_addr = Z_PTR;
            next_s.op_data = STORE_DATA;
            if (s.erase || s.wr || s.lockfuse) begin
                // R13 start timed operation
                next_s.op_busy = 1'b1;
                next_s.timer = TW'(PROG_CYCLES - 1);
                next_s.erase_go = s.erase;
                next_s.write_go = s.wr & ~s.erase;
                next_s.lock_go = s.lockfuse & ~s.erase & ~s.wr;
                // R16 busy set by erase or write
                if (s.erase || s.wr) begin
                    next_s.busy_flag = 1'b1;
                end
            end else begin
                if (s.reen) begin
                    // R16 re-enable clears busy flag
                    next_s.busy_flag = 1'b0;
                    next_s.buf_clear = 1'b1;
                end else begin
                    next_s.buf_load = 1'b1;
                end
                next_s.en = 1'b0;
                next_s.reen = 1'b0;
            end
        end

        // R13 operation length countdown
        if (s.op_busy) begin
            if (s.timer == '0) begin
                next_s.op_busy = 1'b0;
                next_s.en = 1'b0;
                next_s.erase = 1'b0;
                next_s.wr = 1'b0;
                next_s.lockfuse = 1'b0;
                irq_ev[IRQ_DONE] = 1'b1;
            end else begin
                next_s.timer = s.timer - TW'(1);
            end
        end

        // register writes
        if (wr_hit) begin
            case (WB_ADR_I)
                ADR_CTRL: begin
                    if (WB_DAT_I[CB_EN]) begin
                        // R14 R15 refused while enable set or eeprom writes
                        arm_ok = ~s.en & ~EEPROM_WRITE_ACTIVE;
                        if (arm_ok) begin
                            next_s.en = 1'b1;
                            next_s.erase = WB_DAT_I[CB_ERASE];
                            next_s.wr = WB_DAT_I[CB_WRITE];
                            next_s.lockfuse = WB_DAT_I[CB_LOCKFUSE];
                            next_s.reen = WB_DAT_I[CB_REEN];
                            next_s.sig = WB_DAT_I[CB_SIG];
                            next_s.lwin = (WB_DAT_I[CB_LOCKFUSE] | WB_DAT_I[CB_SIG])
                                          ? LOAD_WINDOW : 3'h0;
                            next_s.swin = WB_DAT_I[CB_SIG] ? 3'h0 : STORE_WINDOW;
                        end else begin
                            irq_ev[IRQ_REFUSE] = 1'b1;
                        end
                    end
                end
                ADR_IRQ_STAT: irq_clr = WB_DAT_I[IRQ_W-1:0];
                ADR_IRQ_MASK: next_s.irq_mask = WB_DAT_I[IRQ_W-1:0];
                default: ;
            endcase
        end
        next_s.irq_st = (s.irq_st & ~irq_clr) | irq_ev;

        if (bus_req) begin
            next_s.ack = 1'b1;
            next_s.rdata = ZERO_WORD;
            if (rd_hit) begin
                case (WB_ADR_I)
                    ADR_CTRL: begin
                        next_s.rdata[CB_EN] = s.en;
                        next_s.rdata[CB_ERASE] = s.erase;
                        next_s.rdata[CB_WRITE] = s.wr;
                        next_s.rdata[CB_LOCKFUSE] = s.lockfuse;
                        next_s.rdata[CB_REEN] = s.reen;
                        next_s.rdata[CB_SIG] = s.sig;
                        next_s.rdata[CB_BUSY] = s.busy_flag;
                    end
                    ADR_IRQ_STAT: next_s.rdata[IRQ_W-1:0] = s.irq_st;
                    ADR_IRQ_MASK: next_s.rdata[IRQ_W-1:0] = s.irq_mask;
                    ADR_OP_ADDR:  next_s.rdata[15:0] = s.op_addr;
                    default:      next_s.rdata = ZERO_WORD;
                endcase
            end
        end

        // R12 running operation survives reset
        if (RST) begin
            if (s.op_busy) begin
                next_s = '{
                    en: next_s.en, erase: next_s.erase, wr: next_s.wr,
                    lockfuse: next_s.lockfuse, reen: 1'b0, sig: 1'b0,
                    busy_flag: next_s.busy_flag, lwin: 3'h0, swin: 3'h0,
                    op_busy: next_s.op_busy, timer: next_s.timer,
                    irq_st: '0, irq_mask: '0, ack: 1'b0, rdata: ZERO_WORD,
                    ld_valid: 1'b0, ld_blocked: 1'b0, ld_data: 8'h00,
                    erase_go: 1'b0, write_go: 1'b0, lock_go: 1'b0,
                    buf_load: 1'b0, buf_clear: 1'b0,
                    op_addr: s.op_addr, op_data: s.op_data
                };
            end else begin
                next_s = '0;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        s <= next_s;
    end

    assign WB_DAT_O = s.rdata;
    assign WB_ACK_O = s.ack;
    assign LOAD_VALID = s.ld_valid;
    assign LOAD_DATA = s.ld_data;
    assign LOAD_BLOCKED = s.ld_blocked;
    assign ERASE_START = s.erase_go;
    assign WRITE_START = s.write_go;
    assign LOCK_WRITE_START = s.lock_go;
    assign BUFFER_LOAD = s.buf_load;
    assign BUFFER_CLEAR = s.buf_clear;
    assign OP_ADDR = s.op_addr;
    assign OP_DATA = s.op_data;
    assign FLASH_OP_BUSY = s.op_busy;
    // R17 fetch restricted during erase or write
    assign FETCH_BOOT_ONLY = s.op_busy & (s.erase | s.wr);
    assign IRQ = |(s.irq_st & s.irq_mask);

endmodule : flsr_top

// File: test/flsr_cpu_model.sv
// cpu core model issuing timed load and store instructions
`timescale 1ns/100ps
module flsr_cpu_model (
    input  wire logic        CORE_CLK,
    input  wire logic        WB_ACK_O,
    input  wire logic        go,
    input  wire logic        is_store,
    input  wire logic [2:0]  dly,
    input  wire logic [15:0] z,
    output logic             LOAD_REQ = 1'b0,
    output logic             STORE_REQ = 1'b0,
    output logic      [15:0] Z_PTR,
    output logic      [15:0] STORE_DATA,
    output logic      [7:0]  FLASH_RD_DATA
);
    logic       pend = 1'b0;
    logic [2:0] step = 3'h0;
    logic [2:0] nxt;
    assign Z_PTR = z;
    assign STORE_DATA = {z[7:0], ~z[7:0]};
    // flash array stand-in
    assign FLASH_RD_DATA = ~z[7:0];
    always @(posedge CORE_CLK) begin
        nxt = (WB_ACK_O && pend) ? 3'h2 : ((step != 3'h0) ? step + 3'h1 : 3'h0);
        LOAD_REQ <= 1'b0;
        STORE_REQ <= 1'b0;
        if (WB_ACK_O && pend) pend <= 1'b0;
        if (go) pend <= 1'b1;
        // instruction at chosen edge after the control write
        if (nxt != 3'h0 && nxt == dly) begin
            LOAD_REQ <= !is_store;
            STORE_REQ <= is_store;
            step <= 3'h0;
        end else step <= (nxt == 3'h6) ? 3'h0 : nxt;
    end
endmodule : flsr_cpu_model

// File: test/flsr_sva.sv
// assertion checker on the readback block ports
`timescale 1ns/100ps
module flsr_sva_chk
    import flsr_pkg::*;
#(
    parameter int PROG_CYCLES = 40
) (
    input wire logic        CORE_CLK,
    input wire logic        RST,
    input wire logic        WB_ACK_O,
    input wire logic        LOAD_REQ,
    input wire logic        LOAD_VALID,
    input wire logic [7:0]  LOAD_DATA,
    input wire logic        LOAD_BLOCKED,
    input wire logic        STORE_REQ,
    input wire logic [15:0] Z_PTR,
    input wire logic        ERASE_START,
    input wire logic        WRITE_START,
    input wire logic [15:0] OP_ADDR,
    input wire logic        FLASH_OP_BUSY,
    input wire logic        FETCH_BOOT_ONLY
);
    int cnt;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // busy cycle counter, kept through reset
    always_ff @(posedge CORE_CLK) cnt <= FLASH_OP_BUSY ? cnt + 1 : 0;
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    a_load_answer: assert property (LOAD_REQ |=> LOAD_VALID)
        else $error("load not answered next cycle");
    a_load_quiet: assert property (!LOAD_REQ |=> !LOAD_VALID)
        else $error("load answer without load");
    a_blocked_byte: assert property (
        LOAD_BLOCKED |-> LOAD_VALID && LOAD_DATA == BLOCK_BYTE)
        else $error("blocked load returned wrong byte");
    a_busy_length: assert property ($fell(FLASH_OP_BUSY) |-> cnt == PROG_CYCLES)
        else $error("flash operation length wrong");
    a_start_busy: assert property (
        (ERASE_START || WRITE_START) |-> FLASH_OP_BUSY && FETCH_BOOT_ONLY)
        else $error("erase or write without busy and boot fetch");
    a_start_cause: assert property (
        (ERASE_START || WRITE_START) |-> $past(STORE_REQ) && OP_ADDR == $past(Z_PTR))
        else $error("start without store or wrong address");
    a_boot_only: assert property (FETCH_BOOT_ONLY |-> FLASH_OP_BUSY)
        else $error("boot-only fetch outside operation");
endmodule : flsr_sva_chk

bind flsr_top flsr_sva_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.CORE_CLK(CORE_CLK), .RST(RST),
    .WB_ACK_O(WB_ACK_O), .LOAD_REQ(LOAD_REQ), .LOAD_VALID(LOAD_VALID), .LOAD_DATA(LOAD_DATA),
    .LOAD_BLOCKED(LOAD_BLOCKED), .STORE_REQ(STORE_REQ), .Z_PTR(Z_PTR),
    .ERASE_START(ERASE_START), .WRITE_START(WRITE_START), .OP_ADDR(OP_ADDR),
    .FLASH_OP_BUSY(FLASH_OP_BUSY), .FETCH_BOOT_ONLY(FETCH_BOOT_ONLY));

// File: test/test_flsr.sv
// self-checking bench of the readback block
`timescale 1ns/100ps
module test_fuse_lock_signature_readback;
    import flsr_pkg::*;
    localparam logic [7:0] S1 = 8'h1E, S2 = 8'h93, S3 = 8'h0B;
    logic        CORE_CLK = 1'b0, RST = 1'b1, WB_WE_I = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0;
    logic        go = 1'b0, is_store = 1'b0, EEPROM_WRITE_ACTIVE = 1'b0;
    logic [7:0]  WB_ADR_I = 8'h00;
    logic [31:0] WB_DAT_I = 32'h0000_0000;
    logic [3:0]  WB_SEL_I = 4'h0;
    logic [2:0]  dly = 3'h0;
    logic [15:0] z = 16'h0000;
    logic [7:0]  LOCK_BITS = 8'hC3, FUSE_LOW = 8'h62, FUSE_HIGH = 8'hD9, FUSE_EXT = 8'hF9;
    logic [7:0]  CAL_BYTE = 8'h7A, FLASH_RD_DATA, LOAD_DATA;
    logic [31:0] WB_DAT_O;
    logic [15:0] Z_PTR, STORE_DATA, OP_ADDR, OP_DATA;
    logic        WB_ACK_O, LOAD_REQ, STORE_REQ, LOAD_VALID, LOAD_BLOCKED, ERASE_START, IRQ;
    logic        WRITE_START, LOCK_WRITE_START, BUFFER_LOAD, BUFFER_CLEAR, FLASH_OP_BUSY;
    logic        FETCH_BOOT_ONLY;
    int          num_errors = 0, samples_checked = 0;
    flsr_top #(.PROG_CYCLES(40), .SIG_BYTE1(S1), .SIG_BYTE2(S2), .SIG_BYTE3(S3)) DUT (.*);
    flsr_cpu_model u_cpu (.*);
    always #2 CORE_CLK = ~CORE_CLK;
    task print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge CORE_CLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= w;
        WB_ADR_I <= a;
        WB_DAT_I <= d;
        WB_SEL_I <= 4'hF;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (WB_ACK_O !== 1'b1 && n < 50);
        if (WB_ACK_O !== 1'b1) begin
            num_errors++;
            print_verdict();
        end
        q = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        WB_WE_I <= 1'b0;
        WB_SEL_I <= 4'h0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, q);
        check(q, e);
    endtask : rd
    task automatic op(input logic [31:0] c, input logic s, input logic [2:0] d,
                      input logic [15:0] a);
        logic [31:0] q;
        @(posedge CORE_CLK);
        go <= 1'b1;
        is_store <= s;
        dly <= d;
        z <= a;
        @(posedge CORE_CLK);
        go <= 1'b0;
        wb(1'b1, ADR_CTRL, c, q);
    endtask : op
    task automatic wait_for(input int w);
        int n;
        n = 0;
        #1;
        while (!(w == 0 ? LOAD_VALID : (w == 1 ? (ERASE_START | WRITE_START |
               LOCK_WRITE_START | BUFFER_LOAD | BUFFER_CLEAR) : !FLASH_OP_BUSY))) begin
            @(posedge CORE_CLK);
            #1;
            n++;
            if (n > 200) begin
                num_errors++;
                print_verdict();
            end
        end
    endtask : wait_for
    task automatic s_lockfuse;
        logic [7:0] e [4];
        e = '{FUSE_LOW, LOCK_BITS, FUSE_EXT, FUSE_HIGH};
        for (int i = 0; i < 4; i++) begin
            op(32'h0000_0009, 1'b0, (i == 0) ? 3'h3 : 3'h2, 16'(i));
            wait_for(0);
            check(32'(LOAD_DATA), 32'(e[i]));
            rd(ADR_CTRL, 32'h0000_0000);
        end
    endtask : s_lockfuse
    task automatic s_sig;
        logic [15:0] a [5];
        logic [7:0]  e [5];
        a = '{Z_SIG1, Z_CAL, Z_SIG2, Z_SIG3, 16'h0003};
        e = '{S1, CAL_BYTE, S2, S3, RSVD_BYTE};
        for (int i = 0; i < 5; i++) begin
            op(32'h0000_0021, 1'b0, (i == 4) ? 3'h3 : 3'h2, a[i]);
            wait_for(0);
            check(32'(LOAD_DATA), 32'(e[i]));
            rd(ADR_CTRL, 32'h0000_0000);
        end
    endtask : s_sig
    task automatic s_expire;
        logic [31:0] q;
        op(32'h0000_0021, 1'b0, 3'h4, 16'h1A5C);
        wait_for(0);
        check(32'(LOAD_DATA), 32'h0000_00A3);
        rd(ADR_CTRL, 32'h0000_0000);
        rd(ADR_IRQ_STAT, 32'h0000_0002);
        wb(1'b1, ADR_IRQ_STAT, 32'h0000_0002, q);
        op(32'h0000_0009, 1'b1, 3'h5, 16'h0001);
        repeat (5) @(posedge CORE_CLK);
        #1;
        check(32'(FLASH_OP_BUSY), 32'h0000_0000);
        rd(ADR_IRQ_STAT, 32'h0000_0002);
        wb(1'b1, ADR_IRQ_STAT, 32'h0000_0002, q);
    endtask : s_expire
    task automatic s_ops;
        logic [2:0]  e [3];
        logic [31:0] q;
        e = '{3'b100, 3'b010, 3'b001};
        for (int i = 0; i < 3; i++) begin
            op(32'(1 + (2 << i)), 1'b1, (i == 0) ? 3'h4 : 3'h2, 16'h0140);
            wait_for(1);
            check(32'({ERASE_START, WRITE_START, LOCK_WRITE_START}), 32'(e[i]));
            if (i == 0) begin
                check(32'(FETCH_BOOT_ONLY), 32'h0000_0001);
                op(32'h0000_0000, 1'b0, 3'h2, 16'h0100);
                wait_for(0);
                check(32'({LOAD_BLOCKED, LOAD_DATA}), {23'h0, 1'b1, BLOCK_BYTE});
                @(posedge CORE_CLK);
                RST <= 1'b1;
                repeat (3) @(posedge CORE_CLK);
                RST <= 1'b0;
                #1;
                check(32'(FLASH_OP_BUSY), 32'h0000_0001);
                wb(1'b1, ADR_IRQ_MASK, 32'h0000_0001, q);
            end
            wait_for(2);
            wb(1'b0, ADR_CTRL, 32'h0000_0000, q);
            check(q & 32'h0000_0041, (i < 2) ? 32'h0000_0040 : 32'h0000_0000);
            if (i == 0) begin
                check(32'(IRQ), 32'h0000_0001);
                wb(1'b1, ADR_IRQ_STAT, 32'h0000_0001, q);
                #1;
                check(32'(IRQ), 32'h0000_0000);
            end
            op(32'h0000_0011, 1'b1, 3'h2, 16'h0000);
            wait_for(1);
            check(32'(BUFFER_CLEAR), 32'h0000_0001);
            rd(ADR_CTRL, 32'h0000_0000);
        end
    endtask : s_ops
    task automatic s_refuse;
        logic [31:0] q;
        op(32'h0000_0001, 1'b1, 3'h3, 16'h0A42);
        wait_for(1);
        check(32'({BUFFER_LOAD, OP_DATA}), 32'h0001_42BD);
        rd(ADR_OP_ADDR, 32'h0000_0A42);
        rd(ADR_CTRL, 32'h0000_0000);
        wb(1'b1, ADR_IRQ_STAT, 32'h0000_0007, q);
        @(posedge CORE_CLK);
        EEPROM_WRITE_ACTIVE <= 1'b1;
        wb(1'b1, ADR_CTRL, 32'h0000_0009, q);
        EEPROM_WRITE_ACTIVE <= 1'b0;
        rd(ADR_CTRL, 32'h0000_0000);
        rd(ADR_IRQ_STAT, 32'h0000_0004);
        rd(8'h10, 32'h0000_0000);
    endtask : s_refuse
    initial begin
        repeat (20) @(posedge CORE_CLK);
        RST <= 1'b0;
        s_lockfuse();
        s_sig();
        s_expire();
        s_ops();
        s_refuse();
        print_verdict();
    end
endmodule : test_fuse_lock_signature_readback
